/* File: clk_rate_regs.sv */
// file: rate adjust, page checksum and timestamp readout registers
// assumes a management front end delivering one register access per cycle
// Function
// - rate value is a signed period correction in units of 2^-32 ns
// - each reference cycle the clock advances nominal period plus or minus rate
// - host writes high then low; full rate loads on the low write
// - high register bits 9:0 give upper ten bits of 26-bit magnitude
// - direction bit 15 clear adds magnitude, set subtracts it
// - temporary bit 14 applies rate only for the programmed duration
// - high register bits 13:10 ignore writes and read zero
// - read sum is one's complement sum of all returned read data
// - reading the read sum clears it and is not added to it
// - write sum accumulates all write data, checksum registers included
// - reading the write sum clears it; returned value joins read sum
// - control frame accesses never add to sums but reads still clear
// - transmit stamp is four reads: ns low, ovf and ns high, sec low, high
// - second word top bits count dropped stamps, saturating at three
// - receive stamp adds sequence id then message type with source hash
// - transmit ready drops after read when no further stamp is queued
`timescale 1ns/1ps
module clk_rate_regs
  import clk_rate_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire clk_rate_pkg::reg_req_t req,
  input  wire logic [15:0]           temporary_rate_duration,
  input  wire logic                  tx_capture,
  input  wire clk_rate_pkg::stamp_t  tx_capture_ts,
  input  wire logic                  rx_capture,
  input  wire clk_rate_pkg::stamp_t  rx_capture_ts,
  input  wire clk_rate_pkg::rx_info_t rx_capture_info,
  output logic [15:0]                rd_data_r,
  output logic                       rd_valid_r,
  output logic                       tx_stamp_ready_flag_r,
  output logic                       rx_stamp_ready_r,
  output logic [31:0]                time_sec_r,
  output logic [29:0]                time_ns_r
);
  import clk_rate_pkg::*;

  // ===========================================================
  // declarations
  logic [15:0] rate_low_reg_r;
  logic [15:0] rate_high_reg_r;
  logic [25:0] rate_magnitude_r;
  logic        rate_direction_r;
  logic        temporary_rate_enable_r;
  logic [15:0] tmp_cnt_r;
  logic        rate_on;
  logic [31:0] frac_r;
  logic [63:0] acc;
  logic [15:0] read_sum_value_r;
  logic [15:0] write_sum_value_r;
  logic [2:0]  tx_idx_r;
  logic [2:0]  rx_idx_r;
  logic [15:0] rd_val;
  logic        rd_hit;
  logic        tx_pop;
  logic        rx_pop;
  logic        tx_valid;
  logic        rx_valid;
  logic [63:0] tx_head_bits;
  logic [95:0] rx_head_bits;
  tx_entry_t   tx_head;
  rx_entry_t   rx_head;
  logic        low_wr;

  function automatic logic [15:0] ocadd(input logic [15:0] a,
                                        input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0, s[16]};
  endfunction : ocadd

  assign low_wr = req.wr && req.addr == RATE_LOW_ADDR;

  // ===========================================================
  // rate registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_low_reg_r  <= RATE_LOW_RST;
      rate_high_reg_r <= RATE_HIGH_RST;
    end else begin
      if (low_wr) rate_low_reg_r <= req.wdata;
      if (req.wr && req.addr == RATE_HIGH_ADDR) begin
        rate_high_reg_r <= {req.wdata[RATE_DIR_BIT:RATE_TMP_BIT], 4'h0,
                            req.wdata[RATE_HI_MSB:0]};
      end
    end
  end

  // the adjuster only sees a new rate once the low half arrives
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_magnitude_r        <= 26'h0;
      rate_direction_r        <= 1'b0;
      temporary_rate_enable_r <= 1'b0;
    end else if (low_wr) begin
      rate_magnitude_r <= {rate_high_reg_r[RATE_HI_MSB:0], req.wdata};
      rate_direction_r        <= rate_high_reg_r[RATE_DIR_BIT];
      temporary_rate_enable_r <= rate_high_reg_r[RATE_TMP_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tmp_cnt_r <= 16'h0;
    end else if (low_wr) begin
      tmp_cnt_r <= temporary_rate_duration;
    end else if (temporary_rate_enable_r && tmp_cnt_r != 16'h0) begin
      tmp_cnt_r <= tmp_cnt_r - 16'h1;
    end
  end

  assign rate_on = !temporary_rate_enable_r || tmp_cnt_r != 16'h0;

  // ===========================================================
  // time clock
  always_comb begin
    acc = {2'h0, time_ns_r, frac_r} + NOM_STEP;
    if (rate_on) begin
      if (rate_direction_r) begin
        acc = acc - {38'h0, rate_magnitude_r};
      end else begin
        acc = acc + {38'h0, rate_magnitude_r};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frac_r     <= 32'h0;
      time_ns_r  <= 30'h0;
      time_sec_r <= 32'h0;
    end else begin
      frac_r <= acc[31:0];
      if (acc[63:32] >= {2'h0, NS_PER_SEC}) begin
        time_ns_r  <= acc[61:32] - NS_PER_SEC;
        time_sec_r <= time_sec_r + 32'h1;
      end else begin
        time_ns_r <= acc[61:32];
      end
    end
  end

  // ===========================================================
  // timestamp queues
  stamp_queue #(
    .W     ($bits(stamp_t)),
    .DEPTH (STAMP_DEPTH)
  ) u_tx_queue (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .push       (tx_capture),
    .push_data  (tx_capture_ts),
    .pop        (tx_pop),
    .head_data  (tx_head_bits),
    .head_valid (tx_valid)
  );

  stamp_queue #(
    .W     ($bits(rx_info_t) + $bits(stamp_t)),
    .DEPTH (STAMP_DEPTH)
  ) u_rx_queue (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .push       (rx_capture),
    .push_data  ({rx_capture_info, rx_capture_ts}),
    .pop        (rx_pop),
    .head_data  (rx_head_bits),
    .head_valid (rx_valid)
  );

  assign tx_head = tx_entry_t'(tx_head_bits);
  assign rx_head = rx_entry_t'(rx_head_bits);
  assign tx_pop  = req.rd && req.addr == TX_STAMP_ADDR && tx_valid &&
                   tx_idx_r == TX_LAST_WORD;
  assign rx_pop  = req.rd && req.addr == RX_STAMP_ADDR && rx_valid &&
                   rx_idx_r == RX_LAST_WORD;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_idx_r <= 3'h0;
      rx_idx_r <= 3'h0;
    end else begin
      if (tx_pop) begin
        tx_idx_r <= 3'h0;
      end else if (req.rd && req.addr == TX_STAMP_ADDR && tx_valid) begin
        tx_idx_r <= tx_idx_r + 3'h1;
      end
      if (rx_pop) begin
        rx_idx_r <= 3'h0;
      end else if (req.rd && req.addr == RX_STAMP_ADDR && rx_valid) begin
        rx_idx_r <= rx_idx_r + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_stamp_ready_flag_r <= 1'b0;
      rx_stamp_ready_r      <= 1'b0;
    end else begin
      tx_stamp_ready_flag_r <= tx_valid;
      rx_stamp_ready_r      <= rx_valid;
    end
  end

  // ===========================================================
  // read data selection
  always_comb begin
    rd_val = 16'h0;
    rd_hit = 1'b1;
    case (req.addr)
      RATE_LOW_ADDR:  rd_val = rate_low_reg_r;
      RATE_HIGH_ADDR: rd_val = rate_high_reg_r;
      RD_SUM_ADDR:    rd_val = read_sum_value_r;
      WR_SUM_ADDR:    rd_val = write_sum_value_r;
      TX_STAMP_ADDR: begin
        if (tx_valid) begin
          case (tx_idx_r)
            3'h0:    rd_val = tx_head.ts.ns[15:0];
            3'h1:    rd_val = {tx_head.ovf, tx_head.ts.ns[29:16]};
            3'h2:    rd_val = tx_head.ts.sec[15:0];
            default: rd_val = tx_head.ts.sec[31:16];
          endcase
        end
      end
      RX_STAMP_ADDR: begin
        if (rx_valid) begin
          case (rx_idx_r)
            3'h0:    rd_val = rx_head.ts.ns[15:0];
            3'h1:    rd_val = {rx_head.ovf, rx_head.ts.ns[29:16]};
            3'h2:    rd_val = rx_head.ts.sec[15:0];
            3'h3:    rd_val = rx_head.ts.sec[31:16];
            3'h4:    rd_val = rx_head.info.seq_id;
            default: rd_val = {rx_head.info.msg_type,
                               rx_head.info.src_hash};
          endcase
        end
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_r  <= 16'h0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= req.rd;
      if (req.rd) rd_data_r <= rd_val;
    end
  end

  // ===========================================================
  // page checksums
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      read_sum_value_r <= SUM_RST;
    end else if (req.rd && req.addr == RD_SUM_ADDR) begin
      read_sum_value_r <= SUM_RST;
    end else if (req.rd && rd_hit && !req.ctl_frame) begin
      read_sum_value_r <= ocadd(read_sum_value_r, rd_val);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      write_sum_value_r <= SUM_RST;
    end else if (req.rd && req.addr == WR_SUM_ADDR) begin
      write_sum_value_r <= SUM_RST;
    end else if (req.wr && !req.ctl_frame) begin
      write_sum_value_r <= ocadd(write_sum_value_r, req.wdata);
    end
  end

  // ===========================================================
  // checks
  rate_load_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    low_wr |=> rate_magnitude_r ==
      {$past(rate_high_reg_r[RATE_HI_MSB:0]), $past(req.wdata)})
    else $error("rate not loaded on low write");

  high_rsvd_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (req.wr && req.addr == RATE_HIGH_ADDR) |=>
      rate_high_reg_r == ($past(req.wdata) & 16'hC3FF))
    else $error("rate high store or reserved bits wrong");

  rate_dir_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rate_on && !low_wr) |=> frac_r == ($past(rate_direction_r) ?
      $past(frac_r) - {6'h0, $past(rate_magnitude_r)} :
      $past(frac_r) + {6'h0, $past(rate_magnitude_r)}))
    else $error("fraction step does not follow rate direction");

  rd_sum_clear_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (req.rd && req.addr == RD_SUM_ADDR) |=> read_sum_value_r == 16'h0)
    else $error("read sum not cleared by its read");

  wr_sum_clear_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (req.rd && req.addr == WR_SUM_ADDR) |=> write_sum_value_r == 16'h0)
    else $error("write sum not cleared by its read");

  wr_sum_add_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (req.wr && !req.rd && !req.ctl_frame) |=>
      write_sum_value_r == ocadd($past(write_sum_value_r), $past(req.wdata)))
    else $error("write sum not accumulated");

  ctl_no_sum_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (req.ctl_frame && req.addr != RD_SUM_ADDR && req.addr != WR_SUM_ADDR)
      |=> $stable(read_sum_value_r) && $stable(write_sum_value_r))
    else $error("control frame access changed a sum");

  tx_word_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    tx_pop |=> tx_idx_r == 3'h0 ##1 (tx_valid || !tx_stamp_ready_flag_r))
    else $error("transmit index or ready wrong after last word");

endmodule : clk_rate_regs

/* File: clk_rate_pkg.sv */
// package: constants and carrier types for the clock rate, checksum and
// timestamp register block
// assumes a 20 MHz reference clock and a 5-bit register address space
package clk_rate_pkg;

  // ===========================================================
  // clocking
  localparam int REF_CLK_HZ    = 20_000_000;
  localparam int REF_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
  localparam logic [63:0] NOM_STEP = 64'(REF_PERIOD_NS) << 32;
  localparam logic [29:0] NS_PER_SEC = 30'h3B9ACA00;

  // ===========================================================
  // register offsets
  localparam logic [4:0] RATE_LOW_ADDR  = 5'h18;
  localparam logic [4:0] RATE_HIGH_ADDR = 5'h19;
  localparam logic [4:0] RD_SUM_ADDR    = 5'h1A;
  localparam logic [4:0] WR_SUM_ADDR    = 5'h1B;
  localparam logic [4:0] TX_STAMP_ADDR  = 5'h1C;
  localparam logic [4:0] RX_STAMP_ADDR  = 5'h1D;

  // ===========================================================
  // fields and reset values
  localparam int RATE_DIR_BIT = 15;
  localparam int RATE_TMP_BIT = 14;
  localparam int RATE_HI_MSB  = 9;
  localparam logic [15:0] RATE_LOW_RST  = 16'h0000;
  localparam logic [15:0] RATE_HIGH_RST = 16'h0000;
  localparam logic [15:0] SUM_RST       = 16'h0000;
  localparam logic [2:0]  TX_LAST_WORD  = 3'h3;
  localparam logic [2:0]  RX_LAST_WORD  = 3'h5;
  localparam int STAMP_DEPTH = 4;

  // ===========================================================
  // carriers
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ctl_frame;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } stamp_t;

  typedef struct packed {
    logic [15:0] seq_id;
    logic [3:0]  msg_type;
    logic [11:0] src_hash;
  } rx_info_t;

  typedef struct packed {
    logic [1:0] ovf;
    stamp_t     ts;
  } tx_entry_t;

  typedef struct packed {
    logic [1:0] ovf;
    rx_info_t   info;
    stamp_t     ts;
  } rx_entry_t;

endpackage : clk_rate_pkg

/* File: stamp_queue.sv */
// file: small timestamp queue with saturating drop count per entry
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module stamp_queue #(
  parameter int W     = 62,
  parameter int DEPTH = 4
) (
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           push,
  input  wire logic [W-1:0]   push_data,
  input  wire logic           pop,
  output logic      [W+1:0]   head_data,
  output logic                head_valid
);
  localparam int AW = $clog2(DEPTH);

  logic [W+1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic [1:0]    drop_r;
  logic          push_ok;
  logic          pop_ok;

  assign push_ok    = push && (count_r != (AW+1)'(DEPTH));
  assign pop_ok     = pop && (count_r != '0);
  assign head_data  = mem[rd_ptr_r];
  assign head_valid = (count_r != '0);

  // drops counted since the last stored entry ride in the top two bits
  always_ff @(posedge ref_clk) begin
    if (push_ok) begin
      mem[wr_ptr_r] <= {drop_r, push_data};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drop_r <= 2'h0;
    end else if (push_ok) begin
      drop_r <= 2'h0;
    end else if (push && drop_r != 2'h3) begin
      drop_r <= drop_r + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push_ok) wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop_ok) rd_ptr_r <= rd_ptr_r + AW'(1);
      count_r <= count_r + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
    end
  end

endmodule : stamp_queue

/* File: mgmt_host.sv */
// station management host model: issues one register access per wr or rd call
// assumes the register port takes a request on the rising edge of ref_clk
`timescale 1ns/1ps
module mgmt_host (
  input  wire logic                   ref_clk,
  input  wire logic                   rd_valid_r,
  input  wire logic [15:0]            rd_data_r,
  output clk_rate_pkg::reg_req_t      req
);
  import clk_rate_pkg::*;

  initial req = '0;

  // =========================================================
  // one access: request held for one edge, then released
  task automatic acc(input logic r, input logic [4:0] a,
                     input logic [15:0] d, input logic c);
    @(posedge ref_clk);
    req <= '{rd: r, wr: !r, ctl_frame: c, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
  endtask : acc

  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    input logic c);
    acc(1'b0, a, d, c);
  endtask : wr

  // answer stands from the taking edge and is sampled at the next falling edge
  task automatic rd(input logic [4:0] a, input logic c,
                    output logic v, output logic [15:0] q);
    acc(1'b1, a, 16'h0000, c);
    @(negedge ref_clk);
    v = rd_valid_r;
    q = rd_data_r;
  endtask : rd

  task automatic set_rate(input logic [15:0] hi, input logic [15:0] lo);
    wr(RATE_HIGH_ADDR, hi, 1'b0);
    wr(RATE_LOW_ADDR, lo, 1'b0);
  endtask : set_rate
endmodule : mgmt_host

/* File: tb.sv */
// testbench for the rate, checksum and timestamp register block
// assumes the host model drives the register port
`timescale 1ns/1ps
module tb;
  import clk_rate_pkg::*;
  localparam int NMEAS = 640;
  localparam int NOM   = NMEAS * REF_PERIOD_NS;

  logic        ref_clk;
  logic        rst;
  logic        tx_capture;
  logic        rx_capture;
  logic [15:0] temporary_rate_duration;
  stamp_t      tx_capture_ts;
  stamp_t      rx_capture_ts;
  rx_info_t    rx_capture_info;
  reg_req_t    req;
  logic [15:0] rd_data_r;
  logic        rd_valid_r;
  logic        tx_rdy;
  logic        rx_rdy;
  logic [31:0] time_sec_r;
  logic [29:0] time_ns_r;
  int          n_errors;
  int          check_count;

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  clk_rate_regs i_dut (
    .ref_clk(ref_clk), .rst(rst), .req(req),
    .temporary_rate_duration(temporary_rate_duration),
    .tx_capture(tx_capture), .tx_capture_ts(tx_capture_ts),
    .rx_capture(rx_capture), .rx_capture_ts(rx_capture_ts),
    .rx_capture_info(rx_capture_info),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .tx_stamp_ready_flag_r(tx_rdy), .rx_stamp_ready_r(rx_rdy),
    .time_sec_r(time_sec_r), .time_ns_r(time_ns_r)
  );

  mgmt_host i_host (
    .ref_clk(ref_clk), .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r), .req(req)
  );

  // =========================================================
  // shared helpers
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic rchk(input string nm, input logic [4:0] a,
                      input logic c, input logic [15:0] e);
    logic        v;
    logic [15:0] q;
    i_host.rd(a, c, v, q);
    check({nm, "_valid"}, {31'h0, v}, 32'h1);
    check(nm, {16'h0, q}, {16'h0, e});
  endtask : rchk

  task automatic measure(output logic [31:0] d);
    logic [29:0] t0;
    @(negedge ref_clk);
    t0 = time_ns_r;
    repeat (NMEAS) @(negedge ref_clk);
    d = {2'b00, time_ns_r - t0};
  endtask : measure

  function automatic stamp_t mk(input int k);
    mk.sec = {16'hA000 + 16'(k), 16'h5000 + 16'(k)};
    mk.ns  = {14'(k + 1), 16'h0C00 + 16'(k)};
  endfunction : mk

  // the four time words shared by both stamp ports
  task automatic stamp_words(input logic [4:0] a, input int k,
                             input logic [1:0] ov);
    stamp_t s;
    s = mk(k);
    rchk("ns_lo", a, 1'b0, s.ns[15:0]);
    rchk("ovf_ns_hi", a, 1'b0, {ov, s.ns[29:16]});
    rchk("sec_lo", a, 1'b0, s.sec[15:0]);
    rchk("sec_hi", a, 1'b0, s.sec[31:16]);
  endtask : stamp_words

  // =========================================================
  // scenarios
  task automatic test_reset;
    logic [31:0] d;
    rchk("low_rst", RATE_LOW_ADDR, 1'b0, RATE_LOW_RST);
    rchk("high_rst", RATE_HIGH_ADDR, 1'b0, RATE_HIGH_RST);
    measure(d);
    check("nominal", d, NOM);
    check("sec_start", time_sec_r, 32'h0);
  endtask : test_reset

  task automatic test_sums;
    rchk("rd_sum0", RD_SUM_ADDR, 1'b0, SUM_RST);
    i_host.wr(RATE_HIGH_ADDR, 16'h8001, 1'b0);
    i_host.wr(RD_SUM_ADDR, 16'h9000, 1'b0);
    i_host.wr(5'h05, 16'h1234, 1'b1);
    i_host.wr(5'h05, 16'h0100, 1'b0);
    rchk("high_rd", RATE_HIGH_ADDR, 1'b0, 16'h8001);
    rchk("wr_sum", WR_SUM_ADDR, 1'b0, 16'h1102);
    rchk("wr_sum_clr", WR_SUM_ADDR, 1'b0, 16'h0000);
    rchk("ctl_rd", RATE_HIGH_ADDR, 1'b1, 16'h8001);
    rchk("rd_sum", RD_SUM_ADDR, 1'b1, 16'h9103);
    rchk("rd_sum_clr", RD_SUM_ADDR, 1'b0, 16'h0000);
  endtask : test_sums

  task automatic test_rate;
    logic [31:0] d;
    i_host.wr(RATE_HIGH_ADDR, 16'hBFFF, 1'b0);
    measure(d);
    check("rate_held", d, NOM);
    rchk("high_rb", RATE_HIGH_ADDR, 1'b0, 16'h83FF);
    i_host.wr(RATE_LOW_ADDR, 16'hFFFF, 1'b0);
    measure(d);
    check("rate_slow", {31'h0, d == NOM - 10 || d == NOM - 9}, 1);
    i_host.set_rate(16'h03FF, 16'hFFFF);
    measure(d);
    check("rate_fast", {31'h0, d == NOM + 9 || d == NOM + 10}, 1);
    @(posedge ref_clk);
    temporary_rate_duration <= 16'h0280;
    i_host.set_rate(16'h43FF, 16'hFFFF);
    measure(d);
    check("rate_tmp_on", {31'h0, d == NOM + 9 || d == NOM + 10}, 1);
    measure(d);
    check("rate_tmp_end", d, NOM);
  endtask : test_rate

  task automatic test_tx;
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      tx_capture    <= 1'b1;
      tx_capture_ts <= mk(k);
    end
    @(posedge ref_clk);
    tx_capture <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check("tx_rdy_up", {31'h0, tx_rdy}, 1);
    for (int k = 0; k < STAMP_DEPTH; k++) stamp_words(TX_STAMP_ADDR, k, 2'h0);
    repeat (2) @(negedge ref_clk);
    check("tx_rdy_down", {31'h0, tx_rdy}, 0);
    rchk("tx_empty", TX_STAMP_ADDR, 1'b0, 16'h0000);
    @(posedge ref_clk);
    tx_capture    <= 1'b1;
    tx_capture_ts <= mk(9);
    @(posedge ref_clk);
    tx_capture <= 1'b0;
    repeat (2) @(negedge ref_clk);
    stamp_words(TX_STAMP_ADDR, 9, 2'h3);
  endtask : test_tx

  task automatic test_rx;
    @(posedge ref_clk);
    rx_capture      <= 1'b1;
    rx_capture_ts   <= mk(20);
    rx_capture_info <= '{seq_id: 16'h4321, msg_type: 4'h9,
                         src_hash: 12'h5A6};
    @(posedge ref_clk);
    rx_capture <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check("rx_rdy_up", {31'h0, rx_rdy}, 1);
    stamp_words(RX_STAMP_ADDR, 20, 2'h0);
    rchk("rx_seq", RX_STAMP_ADDR, 1'b0, 16'h4321);
    rchk("rx_type_hash", RX_STAMP_ADDR, 1'b0, 16'h95A6);
    repeat (2) @(negedge ref_clk);
    check("rx_rdy_down", {31'h0, rx_rdy}, 0);
  endtask : test_rx

  // =========================================================
  // verdict, watchdog and main sequence
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (12000) @(posedge ref_clk);
    n_errors++;
    give_verdict;
  end

  initial begin
    rst = 1'b1;
    tx_capture = 1'b0;
    rx_capture = 1'b0;
    temporary_rate_duration = 16'h0000;
    tx_capture_ts = '0;
    rx_capture_ts = '0;
    rx_capture_info = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset;
    test_sums;
    test_rate;
    test_tx;
    test_rx;
    give_verdict;
  end
endmodule : tb
